// File: logic/slrc_pkg.sv
`default_nettype none
// Shared constants and carriers for the sleep and reset controller.
package slrc_pkg;

   // Sleep mode field encodings.
   localparam logic [2:0] MODE_IDLE  = 3'h0;
   localparam logic [2:0] MODE_PDOWN = 3'h2;
   localparam logic [2:0] MODE_PSAVE = 3'h3;
   localparam logic [2:0] MODE_STBY  = 3'h6;
   localparam logic [2:0] MODE_ESTBY = 3'h7;

   // Reset cause flag positions.
   localparam int RST_POR  = 0;
   localparam int RST_EXT  = 1;
   localparam int RST_BOD  = 2;
   localparam int RST_WDOG = 3;
   localparam int RST_DBG  = 4;
   localparam int RST_SW   = 5;
   localparam int RST_NSRC = 6;

   // Wake source positions.
   localparam int WK_TWI  = 0;
   localparam int WK_PORT = 1;
   localparam int WK_USB  = 2;
   localparam int WK_RTC  = 3;
   localparam int WK_NSRC = 4;

   // Halt time after wake, in core cycles.
   localparam int WAKE_HALT_CYC = 4;

   // System clock period and the rate of the internal default oscillator.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int OSC2M_PERIOD_PS = 500000;
   localparam int OSC2M_DIV = OSC2M_PERIOD_PS / CLK_PERIOD_PS;

   // Software reset must be issued within this many core cycles.
   localparam int SWRST_MAX_CYC = 2;

   // Reset values.
   localparam logic [1:0] RST_VEC_DEFAULT = 2'h0;

   // Clock gate bundle driven toward the clock tree.
   typedef struct packed {
      logic cpu;
      logic nvm;
      logic periph;
      logic rtc;
      logic osc;
   } slrc_gate_t;

endpackage
`default_nettype wire

// File: logic/slrc_sync.sv
`default_nettype none
// Two-flop synchroniser for the reset request levels.
module slrc_sync #(
   parameter int WIDTH = 6
) (
   input  wire logic             i_clk_sys,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] stage1; // Read only by stage2.
   logic [WIDTH-1:0] stage2; // Stable copy.

   // Plain two-stage capture; the first stage feeds nothing else.
   always_ff @(posedge i_clk_sys) begin
      stage1 <= i_async;
      stage2 <= stage1;
   end

   assign o_sync = stage2;

endmodule
`default_nettype wire

// File: logic/slrc_stage_timer.sv
`default_nettype none
// Down counter used for each stage of the release sequence.
module slrc_stage_timer #(
   parameter int WIDTH = 16
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_clear,
   input  wire logic             i_load,
   input  wire logic [WIDTH-1:0] i_count,
   output logic                  o_done
);

   logic [WIDTH-1:0] count;      // Remaining cycles.
   logic [WIDTH-1:0] next_count; // Next remaining cycles.

   // Clear takes priority, then load, then count toward zero.
   always_comb begin
      next_count = count;
      if (i_clear) begin
         next_count = '0;
      end else if (i_load) begin
         next_count = i_count;
      end else if (count != '0) begin
         next_count = count - WIDTH'(1);
      end
   end

   // Registers only.
   always_ff @(posedge i_clk_sys) begin
      count <= next_count;
   end

   // Plain zero test: gating it with the load would loop back through
   // the sequencer, whose load depends on this flag.
   assign o_done = (count == '0);

endmodule
`default_nettype wire

// File: logic/slrc_top.sv
`default_nettype none
// Overview of operation
// - Sleep only from active on instruction.
// - Wake lets pending interrupts run first.
// - Core halted four cycles after wake.
// - State kept in sleep; reset fully resets.
// - Idle stops core and memory after programming.
// - Power-down: all clocks stop, async wakes.
// - Power-save adds running counter wake sources.
// - Standby keeps oscillators, gates other clocks.
// - Extended standby keeps oscillators and counter.
// - Peripheral clock gate freezes that peripheral.
// - Any source resets at once, tri-states pins.
// - Reset loads vector and initial register values.
// - Vector zero or boot section start.
// - Three release stages restart on new request.
// - Per-source cause flags, cleared by power-on.
// - Brownout forced on during erase or debug.
// - Reset held while external pin low.
// - Watchdog reset lasts one to two 2 MHz cycles.
// - Software reset within two core cycles.
// - Debug reset only from debug interface.
// - Reset assertion needs no running clock.
// - Default oscillator is internal 2 MHz source.
module slrc_top #(
   parameter int          NUM_PERIPH  = 8,
   parameter int          DELAY_CYC   = 64,
   parameter int          OSCUP_CYC   = 64,
   parameter int          CAL_CYC     = 64,
   parameter logic [15:0] BOOT_VECTOR = 16'h0100
) (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   // Reset sources; the pin input is active low.
   input  wire logic                  i_por,
   input  wire logic                  i_ext_reset_n,
   input  wire logic                  i_brownout_detector_trip,
   input  wire logic                  i_watchdog_timer_timeout,
   input  wire logic                  i_program_debug_interface_rst,
   input  wire logic                  i_sw_reset_write,
   // Brownout control.
   input  wire logic                  i_brownout_detector_sw_en,
   input  wire logic                  i_chip_erase,
   input  wire logic                  i_program_debug_interface_en,
   // Sleep control.
   input  wire logic [2:0]            i_sleep_mode,
   input  wire logic                  i_sleep_enable,
   input  wire logic                  i_sleep_instr,
   input  wire logic                  i_nvm_busy,
   input  wire logic                  i_irq_any,
   input  wire logic [3:0]            i_wake_irq,
   input  wire logic                  i_rtc_enable,
   input  wire logic                  i_boot_vector_sel,
   input  wire logic [NUM_PERIPH-1:0] i_periph_off,
   // Outputs.
   output logic                       o_core_rst,
   output logic                       o_pins_tristate,
   output logic                       o_cpu_run,
   output logic                       o_asleep,
   output logic                       o_wake_irq_take,
   output logic [15:0]                o_reset_vector,
   output logic                       o_osc2m_enable,
   output logic                       o_osc_calibrate,
   output logic                       o_brownout_detector_on,
   output logic                       o_brownout_force_low,
   output logic [5:0]                 o_reset_cause,
   output slrc_pkg::slrc_gate_t       o_gate_off,
   output logic [NUM_PERIPH-1:0]      o_periph_clk_en
);

   // Release sequence states.
   typedef enum logic [2:0] {
      SEQ_HOLD,
      SEQ_DELAY,
      SEQ_OSCUP,
      SEQ_CAL,
      SEQ_RUN
   } slrc_seq_t;

   // Core power states.
   typedef enum logic [1:0] {
      PWR_ACTIVE,
      PWR_WAIT_NVM,
      PWR_SLEEP,
      PWR_WAKE
   } slrc_pwr_t;

   // Asynchronous reset request; assertion reaches the core with no clock.
   logic any_req;
   // Synchronised copies of the six request levels.
   logic [slrc_pkg::RST_NSRC-1:0] req_raw;
   logic [slrc_pkg::RST_NSRC-1:0] req_sync;
   logic [slrc_pkg::RST_NSRC-1:0] req_prev;
   // Software reset request delayed by one cycle.
   logic sw_req;
   logic next_sw_req;
   // Watchdog pulse shaping on the 2 MHz enable.
   logic [7:0] osc_div;
   logic [7:0] next_osc_div;
   logic       osc_tick;
   logic [1:0] wd_cnt;
   logic [1:0] next_wd_cnt;
   logic       wd_prev;
   logic       wd_req;

   // Sequence state.
   slrc_seq_t seq;
   slrc_seq_t next_seq;
   logic      tmr_load;
   logic [15:0] tmr_count;
   logic      tmr_done;

   // Power state and halt counter.
   slrc_pwr_t pwr;
   slrc_pwr_t next_pwr;
   logic [2:0] mode;
   logic [2:0] next_mode;
   logic [2:0] halt_cnt;
   logic [2:0] next_halt_cnt;
   logic       wake_ok;

   // Cause flags.
   logic [5:0] cause;
   logic [5:0] next_cause;

   // Registered outputs.
   logic [15:0] vector;
   logic [15:0] next_vector;

   // Wake filter per mode, used by the power state logic.
   function automatic logic wake_allowed(input logic [2:0] m,
                                         input logic       any,
                                         input logic [3:0] w,
                                         input logic       rtc_on);
      logic async_w;
      async_w = w[slrc_pkg::WK_TWI] | w[slrc_pkg::WK_PORT] |
                w[slrc_pkg::WK_USB];
      case (m)
         slrc_pkg::MODE_IDLE:  wake_allowed = any;
         slrc_pkg::MODE_PDOWN: wake_allowed = async_w;
         slrc_pkg::MODE_STBY:  wake_allowed = async_w;
         slrc_pkg::MODE_PSAVE,
         slrc_pkg::MODE_ESTBY: wake_allowed = async_w |
            (rtc_on & w[slrc_pkg::WK_RTC]);
         default:              wake_allowed = 1'b0;
      endcase
   endfunction

   // Watchdog request lasts one to two 2 MHz periods.
   assign wd_req = (wd_cnt != 2'h0);

   // Combine sources as plain gates so assertion needs no clock.
   assign any_req = i_por | ~i_ext_reset_n | i_brownout_detector_trip |
                    wd_req | i_program_debug_interface_rst |
                    sw_req;

   // Level copies per source; debug reset comes only from its own pin.
   assign req_raw = {sw_req, i_program_debug_interface_rst, wd_req,
                     i_brownout_detector_trip, ~i_ext_reset_n, i_por};

   slrc_sync #(
      .WIDTH (slrc_pkg::RST_NSRC)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_async   (req_raw),
      .o_sync    (req_sync)
   );

   // Divider that gives one-cycle ticks at the 2 MHz rate, plus the
   // watchdog pulse stretcher and the software reset delay.
   always_comb begin
      next_osc_div = osc_div;
      osc_tick     = (osc_div == 8'(slrc_pkg::OSC2M_DIV - 1));
      next_osc_div = osc_tick ? 8'h00 : osc_div + 8'h01;
      next_wd_cnt  = wd_cnt;
      if (i_watchdog_timer_timeout && !wd_prev) begin
         next_wd_cnt = 2'h2;
      end else if (osc_tick && wd_cnt != 2'h0) begin
         next_wd_cnt = wd_cnt - 2'h1;
      end
      // Register the write, so the request follows it one cycle later.
      next_sw_req = i_sw_reset_write;
   end

   // Registers for the divider group.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         osc_div <= 8'h00;
         wd_cnt  <= 2'h0;
         wd_prev <= 1'b0;
         sw_req  <= 1'b0;
      end else begin
         osc_div <= next_osc_div;
         wd_cnt  <= next_wd_cnt;
         wd_prev <= i_watchdog_timer_timeout;
         sw_req  <= next_sw_req;
      end
   end

   // Release sequence: delay, oscillator start, calibration.
   always_comb begin
      next_seq  = seq;
      tmr_load  = 1'b0;
      tmr_count = 16'h0000;
      case (seq)
         SEQ_HOLD: begin
            if (!any_req) begin
               next_seq  = SEQ_DELAY;
               tmr_load  = 1'b1;
               tmr_count = 16'(DELAY_CYC);
            end
         end
         SEQ_DELAY: begin
            if (tmr_done) begin
               next_seq  = SEQ_OSCUP;
               tmr_load  = 1'b1;
               tmr_count = 16'(OSCUP_CYC);
            end
         end
         SEQ_OSCUP: begin
            if (tmr_done) begin
               next_seq  = SEQ_CAL;
               tmr_load  = 1'b1;
               tmr_count = 16'(CAL_CYC);
            end
         end
         SEQ_CAL: begin
            if (tmr_done) begin
               next_seq = SEQ_RUN;
            end
         end
         SEQ_RUN:  next_seq = SEQ_RUN;
         default:  next_seq = SEQ_HOLD;
      endcase
      if (any_req) begin
         next_seq = SEQ_HOLD;
      end
   end

   slrc_stage_timer #(
      .WIDTH (16)
   ) u_timer (
      .i_clk_sys (i_clk_sys),
      .i_clear   (any_req),
      .i_load    (tmr_load),
      .i_count   (tmr_count),
      .o_done    (tmr_done)
   );

   // Sequence register.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         seq <= SEQ_HOLD;
      end else begin
         seq <= next_seq;
      end
   end

   // Sleep entry, wake and post-wake halt.
   always_comb begin
      next_pwr      = pwr;
      next_mode     = mode;
      next_halt_cnt = halt_cnt;
      wake_ok       = wake_allowed(mode, i_irq_any, i_wake_irq,
                                   i_rtc_enable);
      case (pwr)
         PWR_ACTIVE: begin
            if (i_sleep_instr && i_sleep_enable) begin
               next_mode = i_sleep_mode;
               next_pwr  = PWR_WAIT_NVM;
            end
         end
         PWR_WAIT_NVM: begin
            if (!i_nvm_busy) begin
               next_pwr = PWR_SLEEP;
            end
         end
         PWR_SLEEP: begin
            if (wake_ok) begin
               next_pwr      = PWR_WAKE;
               next_halt_cnt = 3'(slrc_pkg::WAKE_HALT_CYC);
            end
         end
         PWR_WAKE: begin
            next_halt_cnt = halt_cnt - 3'h1;
            if (halt_cnt == 3'h1) begin
               next_pwr = PWR_ACTIVE;
            end
         end
         default: next_pwr = PWR_ACTIVE;
      endcase
   end

   // Power state registers; a reset during sleep returns to active.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || any_req) begin
         pwr      <= PWR_ACTIVE;
         mode     <= slrc_pkg::MODE_IDLE;
         halt_cnt <= 3'h0;
      end else begin
         pwr      <= next_pwr;
         mode     <= next_mode;
         halt_cnt <= next_halt_cnt;
      end
   end

   // Cause flags: rising edge of each synchronised request sets its flag.
   always_comb begin
      next_cause = cause | (req_sync & ~req_prev);
      if (req_sync[slrc_pkg::RST_POR]) begin
         // Power-on clears older flags; a source rising now still sets.
         next_cause = 6'h01 | (req_sync & ~req_prev);
      end
      next_vector = i_boot_vector_sel ? BOOT_VECTOR :
                    16'(slrc_pkg::RST_VEC_DEFAULT);
   end

   // Cause and vector registers.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cause    <= 6'h00;
         req_prev <= '0;
         vector   <= 16'h0000;
      end else begin
         cause    <= next_cause;
         req_prev <= req_sync;
         if (seq != SEQ_RUN) begin
            vector <= next_vector;
         end
      end
   end

   // Core reset and pin tristate follow the request without a clock.
   assign o_core_rst      = any_req | (seq != SEQ_RUN);
   assign o_pins_tristate = any_req | (seq != SEQ_RUN);
   assign o_reset_vector  = vector;
   assign o_reset_cause   = cause;
   assign o_osc2m_enable  = (seq == SEQ_OSCUP) | (seq == SEQ_CAL) |
                            (seq == SEQ_RUN);
   assign o_osc_calibrate = (seq == SEQ_CAL);
   assign o_asleep        = (pwr == PWR_SLEEP);
   assign o_cpu_run       = (seq == SEQ_RUN) && (pwr == PWR_ACTIVE);
   // Wake hands the interrupt to the controller, which orders it by
   // priority; the core resumes after the sleep instruction.
   assign o_wake_irq_take = (pwr == PWR_WAKE) && (halt_cnt == 3'h1);

   // Brownout detector forced on at its lowest threshold.
   assign o_brownout_detector_on = i_brownout_detector_sw_en |
                                   i_chip_erase |
                                   i_program_debug_interface_en;
   assign o_brownout_force_low   = !i_brownout_detector_sw_en &&
                                   (i_chip_erase ||
                                    i_program_debug_interface_en);

   // Clock gating per sleep mode.
   always_comb begin
      o_gate_off = '0;
      if (pwr == PWR_SLEEP) begin
         o_gate_off.cpu    = 1'b1;
         o_gate_off.nvm    = 1'b1;
         o_gate_off.periph = (mode != slrc_pkg::MODE_IDLE);
         o_gate_off.rtc    = (mode == slrc_pkg::MODE_PDOWN) |
                             (mode == slrc_pkg::MODE_STBY) |
                             !i_rtc_enable;
         o_gate_off.osc    = (mode == slrc_pkg::MODE_PDOWN) |
                             (mode == slrc_pkg::MODE_PSAVE);
      end
   end

   // Peripheral gates apply in active and idle; deep modes stop all.
   assign o_periph_clk_en = o_gate_off.periph ? '0 : ~i_periph_off;

endmodule
`default_nettype wire

// File: test/slrc_top_asserts.sv
`default_nettype none
// Port checks of the reset sequencer and the sleep controller.
module slrc_chk #(
   parameter int          NUM_PERIPH  = 8,
   parameter logic [15:0] BOOT_VECTOR = 16'h0100
) (
   input wire logic                  i_clk_sys,
   input wire logic                  i_rst,
   input wire logic                  i_por,
   input wire logic                  i_ext_reset_n,
   input wire logic                  i_brownout_detector_trip,
   input wire logic                  i_program_debug_interface_rst,
   input wire logic                  i_sw_reset_write,
   input wire logic                  i_brownout_detector_sw_en,
   input wire logic                  i_chip_erase,
   input wire logic                  i_program_debug_interface_en,
   input wire logic [2:0]            i_sleep_mode,
   input wire logic                  i_sleep_enable,
   input wire logic                  i_sleep_instr,
   input wire logic                  i_boot_vector_sel,
   input wire logic [NUM_PERIPH-1:0] i_periph_off,
   input wire logic                  o_core_rst,
   input wire logic                  o_pins_tristate,
   input wire logic                  o_cpu_run,
   input wire logic                  o_asleep,
   input wire logic                  o_wake_irq_take,
   input wire logic [15:0]           o_reset_vector,
   input wire logic                  o_osc2m_enable,
   input wire logic                  o_osc_calibrate,
   input wire logic                  o_brownout_detector_on,
   input wire logic                  o_brownout_force_low,
   input wire slrc_pkg::slrc_gate_t  o_gate_off,
   input wire logic [NUM_PERIPH-1:0] o_periph_clk_en
);
   // One clock domain, so clocking and disable are declared once.
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   rst_async_a: assert property (
      i_por || !i_ext_reset_n || i_brownout_detector_trip
      || i_program_debug_interface_rst |-> o_core_rst)
      else $error("reset not raised by a source");
   pins_tri_a: assert property (
      i_por || !i_ext_reset_n || i_brownout_detector_trip
      || i_program_debug_interface_rst |-> o_pins_tristate)
      else $error("pins not tristated");
   sw_reset_a: assert property (
      i_sw_reset_write |-> ##[1:2] o_core_rst)
      else $error("software reset late");
   wake_halt_a: assert property (
      $fell(o_asleep) && !o_core_rst |-> !o_cpu_run [*4] ##1 o_cpu_run)
      else $error("halt after wake not four cycles");
   wake_take_a: assert property (
      o_wake_irq_take |=> o_cpu_run) else $error("take without resume");
   vector_sel_a: assert property (
      $fell(o_core_rst) |-> o_reset_vector ==
      (i_boot_vector_sel ? BOOT_VECTOR : 16'h0000))
      else $error("reset vector wrong");
   cal_osc_a: assert property (
      o_osc_calibrate |-> o_osc2m_enable && o_core_rst)
      else $error("calibration without oscillator");
   bod_force_a: assert property (
      !i_brownout_detector_sw_en && (i_chip_erase ||
      i_program_debug_interface_en) |-> o_brownout_detector_on
      && o_brownout_force_low) else $error("brownout not forced");
   periph_gate_a: assert property (
      (i_periph_off & o_periph_clk_en) == '0)
      else $error("gated peripheral clocked");
   sleep_noen_a: assert property (
      i_sleep_instr && !i_sleep_enable && !o_asleep |-> ##2 !o_asleep)
      else $error("sleep without enable");
   idle_gate_a: assert property (
      o_asleep && i_sleep_mode == slrc_pkg::MODE_IDLE |-> o_gate_off.cpu
      && o_gate_off.nvm && !o_gate_off.periph) else $error("idle gates");
   pdown_gate_a: assert property (
      o_asleep && i_sleep_mode == slrc_pkg::MODE_PDOWN |-> o_gate_off.osc
      && o_gate_off.rtc && o_gate_off.periph) else $error("pdown gates");
   stby_gate_a: assert property (
      o_asleep && i_sleep_mode == slrc_pkg::MODE_STBY |-> !o_gate_off.osc
      && o_gate_off.rtc && o_gate_off.cpu) else $error("standby gates");
endmodule
bind slrc_top slrc_chk #(.NUM_PERIPH(NUM_PERIPH),
   .BOOT_VECTOR(BOOT_VECTOR)) u_chk (.*);
`default_nettype wire

// File: test/slrc_far_model.sv
`default_nettype none
// Stand-in for the core and for whoever presses the reset button.
module slrc_far_model #(
   parameter int PIN_CYC = 8 // Low time, longer than the minimum pulse.
) (
   input  wire logic i_clk_sys,
   input  wire logic i_cpu_run,
   input  wire logic i_sleep_req,
   input  wire logic i_pin_req,
   output logic      o_sleep_instr,
   output logic      o_ext_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int pin_cnt = 0; // Cycles of low pin still to go.
   // A halted core executes nothing, so it cannot issue the instruction.
   always @(posedge i_clk_sys) begin
      o_sleep_instr <= i_sleep_req && (i_cpu_run === 1'b1);
      if (i_pin_req) begin
         pin_cnt = PIN_CYC;
      end
      // The pull-up returns the pin high once released.
      o_ext_reset_n <= (pin_cnt == 0);
      if (pin_cnt > 0) begin
         pin_cnt--;
      end
   end
endmodule
`default_nettype wire

// File: test/tb.sv
`default_nettype none
// Self-checking bench; stage lengths are shortened to keep runs brief.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          STG  = 8;
   localparam logic [15:0] BOOT = 16'h0100;
   logic i_clk_sys, i_rst, i_por, i_brownout_detector_trip;
   logic i_watchdog_timer_timeout, i_program_debug_interface_rst;
   logic i_sw_reset_write, i_brownout_detector_sw_en, i_chip_erase;
   logic i_program_debug_interface_en, i_sleep_enable, i_nvm_busy;
   logic i_irq_any, i_rtc_enable, i_boot_vector_sel, i_ext_reset_n;
   logic i_sleep_instr, slp_req, pin_req, cal_seen;
   logic [2:0] i_sleep_mode;
   logic [3:0] i_wake_irq;
   logic [7:0] i_periph_off, o_periph_clk_en;
   logic o_core_rst, o_pins_tristate, o_cpu_run, o_asleep;
   logic o_wake_irq_take, o_osc2m_enable, o_osc_calibrate;
   logic o_brownout_detector_on, o_brownout_force_low;
   logic [15:0] o_reset_vector;
   logic [5:0] o_reset_cause, cause_exp; // Expected flags so far.
   slrc_pkg::slrc_gate_t o_gate_off;
   int num_errors = 0;
   int checks_done = 0;

   slrc_top #(.NUM_PERIPH(8), .DELAY_CYC(STG), .OSCUP_CYC(STG),
      .CAL_CYC(STG), .BOOT_VECTOR(BOOT)) DUT (.*);
   slrc_far_model far (.i_clk_sys, .i_cpu_run(o_cpu_run),
      .i_sleep_req(slp_req), .i_pin_req(pin_req),
      .o_sleep_instr(i_sleep_instr), .o_ext_reset_n(i_ext_reset_n));

   always #2.5 i_clk_sys = ~i_clk_sys;

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic summarize();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Lets n edges pass and lands where their updates have settled.
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   // Bounded wait for reset release; n is the cycles spent waiting.
   task automatic wait_run(output int n);
      n = 0;
      cal_seen = 1'b0;
      while (o_core_rst !== 1'b0) begin
         cal_seen |= (o_osc_calibrate === 1'b1);
         tick(1);
         n++;
         if (n > 600) begin
            chk("reset release", 16'h0, 16'h1);
            summarize();
         end
      end
   endtask

   // Asks the core model for one sleep instruction.
   task automatic go_sleep(input logic [2:0] m);
      @(posedge i_clk_sys);
      i_sleep_mode <= m;
      slp_req <= 1'b1;
      @(posedge i_clk_sys);
      slp_req <= 1'b0;
      tick(4);
   endtask

   // Raises a wake source and judges latency and the single take pulse.
   task automatic wake(input logic [3:0] w);
      int n, takes;
      @(posedge i_clk_sys);
      i_rtc_enable <= 1'b1;
      i_wake_irq <= w;
      i_irq_any <= 1'b1;
      @(posedge i_clk_sys);
      i_wake_irq <= 4'h0;
      i_irq_any <= 1'b0;
      #1;
      n = 1;
      takes = 0;
      while (o_cpu_run !== 1'b1 && n < 20) begin
         takes += (o_wake_irq_take === 1'b1);
         tick(1);
         n++;
      end
      chk("wake latency", 16'h1, 16'(n >= 5 && n <= 8));
      chk("wake take", 16'h1, 16'(takes));
   endtask

   // Enters a mode; outside idle, offers a counter wake while the counter is off.
   task automatic t_sleep(input logic [2:0] m, input logic [3:0] w,
                          input logic osc_off);
      go_sleep(m);
      chk("asleep", 16'h1, 16'(o_asleep));
      chk("osc gate", 16'(osc_off), 16'(o_gate_off.osc));
      if (m != slrc_pkg::MODE_IDLE) begin
         @(posedge i_clk_sys);
         i_rtc_enable <= 1'b0;
         i_wake_irq <= 4'h8;
         i_irq_any <= 1'b1;
         tick(3);
         chk("wrong wake", 16'h1, 16'(o_asleep));
      end
      wake(w);
   endtask

   // Triggers one reset source and checks its flag and the vector.
   task automatic t_src(input int b, input int lo, input int hi);
      int n;
      @(posedge i_clk_sys);
      case (b)
         slrc_pkg::RST_POR:  ;
         slrc_pkg::RST_EXT:  pin_req <= 1'b1;
         slrc_pkg::RST_BOD:  i_brownout_detector_trip <= 1'b1;
         slrc_pkg::RST_WDOG: i_watchdog_timer_timeout <= 1'b1;
         slrc_pkg::RST_DBG:  i_program_debug_interface_rst <= 1'b1;
         default:            i_sw_reset_write <= 1'b1;
      endcase
      @(posedge i_clk_sys);
      pin_req <= 1'b0;
      i_sw_reset_write <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      i_brownout_detector_trip <= 1'b0;
      i_watchdog_timer_timeout <= 1'b0;
      i_program_debug_interface_rst <= 1'b0;
      tick(1);
      wait_run(n);
      cause_exp[b] = 1'b1;
      chk("reset time", 16'h1, 16'(n >= lo && n <= hi));
      chk("cause", 16'(cause_exp), 16'(o_reset_cause));
      chk("vector", i_boot_vector_sel ? BOOT : 16'h0,
          o_reset_vector);
      chk("running", 16'h1, 16'(o_cpu_run));
   endtask

   initial begin
      {i_clk_sys, i_brownout_detector_trip, i_watchdog_timer_timeout} = '0;
      {i_program_debug_interface_rst, i_sw_reset_write, i_chip_erase} = '0;
      {i_program_debug_interface_en, i_nvm_busy, i_irq_any} = '0;
      {i_rtc_enable, i_boot_vector_sel, slp_req, pin_req} = '0;
      {i_rst, i_por, i_sleep_enable, i_brownout_detector_sw_en} = '1;
      i_sleep_mode = slrc_pkg::MODE_IDLE;
      i_wake_irq = 4'h0;
      i_periph_off = 8'h00;
      cause_exp = 6'h01;
      repeat (16) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      i_por <= 1'b0;
      // Power-on sets only its own flag; the release runs all stages.
      t_src(slrc_pkg::RST_POR, 2 * STG, 60);
      chk("calibration", 16'h1, 16'(cal_seen));
      t_src(slrc_pkg::RST_EXT, 3 * STG, 60);
      // A second request in mid-sequence starts the stages over.
      t_src(slrc_pkg::RST_DBG, 3 * STG, 60);
      @(posedge i_clk_sys) i_program_debug_interface_rst <= 1'b1;
      @(posedge i_clk_sys) i_program_debug_interface_rst <= 1'b0;
      tick(STG + 2);
      t_src(slrc_pkg::RST_DBG, 3 * STG, 60);
      @(posedge i_clk_sys) i_boot_vector_sel <= 1'b1;
      t_src(slrc_pkg::RST_WDOG, 110, 240);
      @(posedge i_clk_sys) i_boot_vector_sel <= 1'b0;
      t_src(slrc_pkg::RST_SW, 3 * STG, 60);
      t_sleep(slrc_pkg::MODE_IDLE, 4'h2, 1'b0);
      t_sleep(slrc_pkg::MODE_PDOWN, 4'h1, 1'b1);
      t_sleep(slrc_pkg::MODE_PSAVE, 4'h8, 1'b1);
      t_sleep(slrc_pkg::MODE_STBY, 4'h4, 1'b0);
      t_sleep(slrc_pkg::MODE_ESTBY, 4'h8, 1'b0);
      // Sleep waits for programming, then a reset ends sleep in full.
      @(posedge i_clk_sys) i_nvm_busy <= 1'b1;
      go_sleep(slrc_pkg::MODE_IDLE);
      chk("nvm wait", 16'h0, 16'(o_asleep));
      @(posedge i_clk_sys) i_nvm_busy <= 1'b0;
      tick(3);
      chk("nvm done", 16'h1, 16'(o_asleep));
      t_src(slrc_pkg::RST_BOD, 3 * STG, 60);
      @(posedge i_clk_sys) i_sleep_enable <= 1'b0;
      go_sleep(slrc_pkg::MODE_PDOWN);
      chk("no enable", 16'h0, 16'(o_asleep));
      @(posedge i_clk_sys);
      i_periph_off <= 8'hA5;
      i_brownout_detector_sw_en <= 1'b0;
      i_chip_erase <= 1'b1;
      tick(1);
      chk("periph clocks", 16'h005A, 16'(o_periph_clk_en));
      chk("bod erase", 16'h3, 16'({o_brownout_detector_on,
          o_brownout_force_low}));
      @(posedge i_clk_sys);
      i_chip_erase <= 1'b0;
      i_program_debug_interface_en <= 1'b1;
      tick(1);
      chk("bod debug", 16'h3, 16'({o_brownout_detector_on,
          o_brownout_force_low}));
      summarize();
   end
endmodule
`default_nettype wire
